// >>> rtl/suspend_state_shadow_readback.sv
// suspend shadow readback: mirrors write-only dma mode/command state and
// selects base or current views for the dma and timer read ports.
// assumes io_wr/io_rd are one-cycle strobes with address and data valid,
// and that the dma and timer cores supply both base and current values.
`timescale 1ns/1ps

module suspend_state_shadow_readback
	import shadow_pkg::*;
#(
	parameter int ADDR_W = 16, // io address width
	parameter int DATA_W = 16  // io data width
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] io_addr,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [DATA_W-1:0] io_wdata,
	input  wire logic [15:0]       dma_base_value,
	input  wire logic [15:0]       dma_current_value,
	input  wire logic [15:0]       timer_base_count,
	input  wire logic [15:0]       timer_current_count,
	output logic [DATA_W-1:0]      io_rdata,
	output logic                   io_rvalid,
	output logic                   view_select
);

	// ************************************************************
	// shadow storage
	// ************************************************************
	// six mode bits per channel: {mode[1:0], dec, auto, type[1:0]}
	logic [5:0] mode_reg [8];
	logic [5:0] mode_next [8];
	logic [2:0] cmd1_reg;          // first controller {extw, rot, dis}
	logic [2:0] cmd2_reg;          // second controller {extw, rot, dis}
	logic       view_select_reg;   // base/current view control
	logic [DATA_W-1:0] rdata_reg;  // registered read data
	logic              rvalid_reg; // read answer strobe

	// ************************************************************
	// write decode
	// ************************************************************
	wire wr_mode1 = io_wr && (io_addr == DMA1_MODE_ADDR);
	wire wr_mode2 = io_wr && (io_addr == DMA2_MODE_ADDR);
	wire wr_cmd1  = io_wr && (io_addr == DMA1_CMD_ADDR);
	wire wr_cmd2  = io_wr && (io_addr == DMA2_CMD_ADDR);
	wire wr_view  = io_wr && (io_addr == SHADOW_CMD_ADDR);

	// mode byte as stored: mode, dec, auto, type
	wire [5:0] mode_fields = {io_wdata[7:6], io_wdata[MODE_DEC_BIT],
		io_wdata[MODE_AUTO_BIT], io_wdata[3:2]};
	wire [2:0] cmd_fields = {io_wdata[CMD_EXTW_BIT], io_wdata[CMD_ROT_BIT],
		io_wdata[CMD_DIS_BIT]};

	// next value per channel: channel index in mode byte bits 1:0
	always_comb begin
		for (int ch = 0; ch < 8; ch++) begin
			mode_next[ch] = mode_reg[ch];
		end
		if (wr_mode1) begin
			mode_next[{1'b0, io_wdata[1:0]}] = mode_fields;
		end
		if (wr_mode2) begin
			mode_next[{1'b1, io_wdata[1:0]}] = mode_fields;
		end
	end

	// ************************************************************
	// shadow registers
	// ************************************************************
	// written values captured for readback
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int ch = 0; ch < 8; ch++) begin
				mode_reg[ch] <= MODE_FIELDS_RESET;
			end
		end else begin
			for (int ch = 0; ch < 8; ch++) begin
				mode_reg[ch] <= mode_next[ch];
			end
		end
	end

	// command shadows and view select
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd1_reg        <= CMD_FIELDS_RESET;
			cmd2_reg        <= CMD_FIELDS_RESET;
			view_select_reg <= VIEW_SEL_RESET;
		end else begin
			if (wr_cmd1) begin
				cmd1_reg <= cmd_fields;
			end
			if (wr_cmd2) begin
				cmd2_reg <= cmd_fields;
			end
			if (wr_view) begin
				view_select_reg <= io_wdata[VIEW_SEL_BIT];
			end
		end
	end

	// ************************************************************
	// readback assembly
	// ************************************************************
	// channel 2 dec and auto at top
	wire [15:0] shadow_low = {mode_reg[2][3], mode_reg[2][2], mode_reg[2][1:0],
		mode_reg[1][5:4], mode_reg[1][3], mode_reg[1][2], mode_reg[1][1:0],
		mode_reg[0][5:4], mode_reg[0][3], mode_reg[0][2], mode_reg[0][1:0]};

	wire [15:0] shadow_mid = {mode_reg[6][1:0], mode_reg[5][5:0],
		mode_reg[3][5:0], mode_reg[2][5:4]};

	wire [2:0] cmd_view = view_select_reg ? cmd2_reg : cmd1_reg;

	// bits 14 and 11 read zero
	// channel 6 mode, dec, auto at 3:0
	wire [15:0] shadow_cmd = {view_select_reg, 1'b0, cmd_view[2], cmd_view[1],
		1'b0, cmd_view[0], mode_reg[7][5:0], mode_reg[6][5:2]};

	wire is_dma_port   = (io_addr <= DMA_PORT_LAST);
	wire is_timer_port = (io_addr >= TIMER_PORT_FIRST) && (io_addr <= TIMER_PORT_LAST);

	wire [15:0] dma_view = view_select_reg ? dma_base_value : dma_current_value;
	wire [15:0] timer_view = view_select_reg ? timer_base_count : timer_current_count;

	// unmapped ports, mode and command ports read zero
	wire [15:0] read_mux =
		(io_addr == SHADOW_LOW_ADDR) ? shadow_low :
		(io_addr == SHADOW_MID_ADDR) ? shadow_mid :
		(io_addr == SHADOW_CMD_ADDR) ? shadow_cmd :
		is_dma_port                  ? dma_view   :
		is_timer_port                ? timer_view : 16'h0000;

	// one-cycle registered read answer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_reg  <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= io_rd;
			if (io_rd) begin
				rdata_reg <= DATA_W'(read_mux);
			end
		end
	end

	assign io_rdata    = rdata_reg;
	assign io_rvalid   = rvalid_reg;
	assign view_select = view_select_reg;

	// ************************************************************
	// hazards and limits
	// ************************************************************
	// the mode and command ports stay write-only, as on the original
	// controllers; a read there answers zero so old drivers see no change.
	// channel 4 is captured like the others but has no place in any view,
	// since the cascade channel is never reprogrammed by a resume routine.
	// the base and current values are taken as they stand at the read edge;
	// a core that moves its count in that same cycle shows the old value.
	// a write and a read in one cycle are not expected on this port bus;
	// the read then shows the shadow contents from before the write.
	// view select flips both the dma and the timer views at once, so a
	// resume routine must clear it before it hands the ports back.
	// only bit 15 of the command shadow is writable; bits 14:0 of a write
	// there are dropped, which keeps the channel fields safe from a stray
	// restore of the whole word.
	// the read answer is registered, trading one cycle of latency for an
	// output that never glitches while the address settles.

	// ************************************************************
	// assertions
	// ************************************************************
	// read strobes on the three shadow ports, shared by the field checks
	sequence low_read_s;
		io_rd && io_addr == SHADOW_LOW_ADDR;
	endsequence
	sequence mid_read_s;
		io_rd && io_addr == SHADOW_MID_ADDR;
	endsequence
	sequence cmd_read_s;
		io_rd && io_addr == SHADOW_CMD_ADDR;
	endsequence

	cmd_view_a: assert property (@(posedge clk) disable iff (reset)
		io_rd && io_addr == SHADOW_CMD_ADDR |=> io_rdata[13] ==
		$past(view_select_reg ? cmd2_reg[2] : cmd1_reg[2]))
		else $error("command shadow bit 13 wrong");
	cmd_rot_a: assert property (@(posedge clk) disable iff (reset)
		cmd_read_s |=> io_rdata[12] ==
		$past(view_select_reg ? cmd2_reg[1] : cmd1_reg[1]))
		else $error("command shadow bit 12 wrong");
	cmd_dis_a: assert property (@(posedge clk) disable iff (reset)
		cmd_read_s |=> io_rdata[10] ==
		$past(view_select_reg ? cmd2_reg[0] : cmd1_reg[0]))
		else $error("command shadow bit 10 wrong");
	reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
		io_rd && io_addr == SHADOW_CMD_ADDR |=> io_rdata[14] == 1'b0 && io_rdata[11] == 1'b0)
		else $error("reserved bits not zero");
	view_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_view |=> view_select == $past(io_wdata[VIEW_SEL_BIT]))
		else $error("view select not written");
	view_hold_a: assert property (@(posedge clk) disable iff (reset)
		!wr_view |=> $stable(view_select))
		else $error("view select changed unwritten");
	ch2_dec_a: assert property (@(posedge clk) disable iff (reset)
		wr_mode1 && io_wdata[1:0] == 2'b10 |=> shadow_low[15] == $past(io_wdata[MODE_DEC_BIT]))
		else $error("channel 2 decrement not shadowed");
	ch2_auto_a: assert property (@(posedge clk) disable iff (reset)
		wr_mode1 && io_wdata[1:0] == 2'b10 |=> shadow_low[14] == $past(io_wdata[MODE_AUTO_BIT]))
		else $error("channel 2 autoinit not shadowed");
	ch1_fields_a: assert property (@(posedge clk) disable iff (reset)
		low_read_s |=> io_rdata[11:6] == $past(mode_reg[1]))
		else $error("channel 1 fields wrong");
	ch0_fields_a: assert property (@(posedge clk) disable iff (reset)
		low_read_s |=> io_rdata[5:0] == $past(mode_reg[0]))
		else $error("channel 0 fields wrong");
	ch2_type_a: assert property (@(posedge clk) disable iff (reset)
		low_read_s |=> io_rdata[13:12] == $past(mode_reg[2][1:0]))
		else $error("channel 2 type wrong");
	ch5_mode_a: assert property (@(posedge clk) disable iff (reset)
		wr_mode2 && io_wdata[1:0] == 2'b01 |=> shadow_mid[13:12] == $past(io_wdata[7:6]))
		else $error("channel 5 mode not shadowed");
	ch5_type_a: assert property (@(posedge clk) disable iff (reset)
		mid_read_s |=> io_rdata[9:8] == $past(mode_reg[5][1:0]))
		else $error("channel 5 type wrong");
	ch3_fields_a: assert property (@(posedge clk) disable iff (reset)
		mid_read_s |=> io_rdata[7:2] == $past(mode_reg[3]))
		else $error("channel 3 fields wrong");
	ch2_mode_a: assert property (@(posedge clk) disable iff (reset)
		mid_read_s |=> io_rdata[1:0] == $past(mode_reg[2][5:4]))
		else $error("channel 2 mode wrong");
	ch6_type_a: assert property (@(posedge clk) disable iff (reset)
		mid_read_s |=> io_rdata[15:14] == $past(mode_reg[6][1:0]))
		else $error("channel 6 type wrong");
	ch6_rest_a: assert property (@(posedge clk) disable iff (reset)
		cmd_read_s |=> io_rdata[3:0] == $past(mode_reg[6][5:2]))
		else $error("channel 6 low fields wrong");
	ch7_type_a: assert property (@(posedge clk) disable iff (reset)
		wr_mode2 && io_wdata[1:0] == 2'b11 |=> shadow_cmd[5:4] == $past(io_wdata[3:2]))
		else $error("channel 7 type not shadowed");
	ch7_fields_a: assert property (@(posedge clk) disable iff (reset)
		cmd_read_s |=> io_rdata[9:4] == $past(mode_reg[7]))
		else $error("channel 7 fields wrong");
	dma_base_a: assert property (@(posedge clk) disable iff (reset)
		io_rd && is_dma_port && view_select_reg |=> io_rdata == $past(dma_base_value))
		else $error("dma base view wrong");
	dma_cur_a: assert property (@(posedge clk) disable iff (reset)
		io_rd && is_dma_port && !view_select_reg |=> io_rdata == $past(dma_current_value))
		else $error("dma current view wrong");
	timer_base_a: assert property (@(posedge clk) disable iff (reset)
		io_rd && is_timer_port && view_select_reg |=> io_rdata == $past(timer_base_count))
		else $error("timer base view wrong");
	timer_cur_a: assert property (@(posedge clk) disable iff (reset)
		io_rd && is_timer_port && !view_select_reg |=> io_rdata == $past(timer_current_count))
		else $error("timer current view wrong");
	// original mode and command ports read zero
	orig_zero_a: assert property (@(posedge clk) disable iff (reset)
		io_rd && (io_addr == DMA1_MODE_ADDR || io_addr == DMA2_MODE_ADDR ||
		io_addr == DMA1_CMD_ADDR || io_addr == DMA2_CMD_ADDR) |=> io_rdata == '0)
		else $error("original port readable");
	// read answer one cycle after strobe
	rvalid_pulse_a: assert property (@(posedge clk) disable iff (reset)
		io_rd |=> io_rvalid)
		else $error("read answer missing");
	rvalid_idle_a: assert property (@(posedge clk) disable iff (reset)
		!io_rd |=> !io_rvalid && $stable(io_rdata))
		else $error("read answer without strobe");
	ch0_capture_a: assert property (@(posedge clk) disable iff (reset)
		wr_mode1 && io_wdata[1:0] == 2'b00 |=> mode_reg[0] == $past(mode_fields))
		else $error("channel 0 mode not captured");

endmodule // suspend_state_shadow_readback

// >>> rtl/shadow_pkg.sv
// package for the suspend shadow readback block: port addresses, field layout, reset values
// assumes an io port decode outside delivers full 16-bit port addresses
package shadow_pkg;

	// ************************************************************
	// port addresses
	// ************************************************************
	localparam logic [15:0] SHADOW_LOW_ADDR  = 16'h3C72; // first mode shadow
	localparam logic [15:0] SHADOW_MID_ADDR  = 16'h4472; // second mode shadow
	localparam logic [15:0] SHADOW_CMD_ADDR  = 16'h4C72; // command shadow and view select
	localparam logic [15:0] DMA1_MODE_ADDR   = 16'h000B; // first controller mode port
	localparam logic [15:0] DMA1_CMD_ADDR    = 16'h0008; // first controller command port
	localparam logic [15:0] DMA2_MODE_ADDR   = 16'h00D6; // second controller mode port
	localparam logic [15:0] DMA2_CMD_ADDR    = 16'h00D0; // second controller command port
	localparam logic [15:0] DMA_PORT_LAST    = 16'h0007; // last address/count port
	localparam logic [15:0] TIMER_PORT_FIRST = 16'h0040; // first timer port
	localparam logic [15:0] TIMER_PORT_LAST  = 16'h0043; // last timer port

	// ************************************************************
	// field positions in the written mode and command bytes
	// ************************************************************
	localparam int MODE_DEC_BIT   = 5;  // address decrement in mode byte
	localparam int MODE_AUTO_BIT  = 4;  // autoinitialize in mode byte
	localparam int CMD_EXTW_BIT   = 5;  // extended write in command byte
	localparam int CMD_ROT_BIT    = 4;  // rotating priority in command byte
	localparam int CMD_DIS_BIT    = 2;  // controller disable in command byte
	localparam int VIEW_SEL_BIT   = 15; // view select in command shadow

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [5:0] MODE_FIELDS_RESET = 6'h00; // per-channel mode shadow
	localparam logic [2:0] CMD_FIELDS_RESET  = 3'h0;  // per-controller command shadow
	localparam logic       VIEW_SEL_RESET    = 1'b0;  // live values after reset

endpackage : shadow_pkg

// >>> verif/suspend_state_shadow_readback_bench.sv
// bench for the suspend shadow readback block: table of write/read rows, then hand tests
// assumes the read answer arrives exactly one cycle after io_rd, as the hand-over fixes
`timescale 1ns/1ps

module suspend_state_shadow_readback_bench import shadow_pkg::*; ;
	// ****************************************
	// signals and reference state
	// ****************************************
	logic        clk, reset, io_wr, io_rd, io_rvalid, view_select;
	logic [15:0] io_addr, io_wdata, io_rdata;
	logic [15:0] dma_base_value, dma_current_value, timer_base_count, timer_current_count;
	logic [5:0]  m [8];      // per-channel mode fields {mode, dec, auto, type}
	logic [2:0]  c [2];      // per-controller {extw, rot, disable}
	logic        v;          // expected view select
	int          num_errors, samples_checked;
	// rows: write address, write data, read address
	logic [47:0] rows [22] = '{48'h000B_0096_3C72, 48'h000B_00E4_3C72, 48'h000B_0069_3C72,
		48'h000B_007B_4472, 48'h00D6_00A5_4472, 48'h00D6_005E_4472, 48'h00D6_00CB_4C72,
		48'h00D6_00FC_4C72, 48'h0008_0034_4C72, 48'h00D0_0010_4C72, 48'h3C72_FFFF_3C72,
		48'h4472_FFFF_4472, 48'h4C72_7FFF_4C72, 48'h4C72_8000_4C72, 48'h0100_0000_0000,
		48'h0100_0000_0043, 48'h000B_003A_3C72, 48'h4C72_0000_0007, 48'h0100_0000_0040,
		48'h0100_0000_000B, 48'h0100_0000_00D0, 48'h0100_0000_0044};

	suspend_state_shadow_readback u_suspend_state_shadow_readback (.clk(clk), .reset(reset),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.dma_base_value(dma_base_value), .dma_current_value(dma_current_value),
		.timer_base_count(timer_base_count), .timer_current_count(timer_current_count),
		.io_rdata(io_rdata), .io_rvalid(io_rvalid), .view_select(view_select));

	// free-running 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****************************************
	// reference model and compares
	// ****************************************
	// expected read value; unmapped and original ports read zero
	function automatic logic [15:0] expv(input logic [15:0] a);
		logic [2:0] k;
		k = v ? c[1] : c[0];
		if (a == SHADOW_LOW_ADDR) return {m[2][3:0], m[1], m[0]};
		if (a == SHADOW_MID_ADDR) return {m[6][1:0], m[5], m[3], m[2][5:4]};
		if (a == SHADOW_CMD_ADDR) return {v, 1'b0, k[2:1], 1'b0, k[0], m[7], m[6][5:2]};
		if (a <= DMA_PORT_LAST) return v ? dma_base_value : dma_current_value;
		if (a >= TIMER_PORT_FIRST && a <= TIMER_PORT_LAST)
			return v ? timer_base_count : timer_current_count;
		return 16'h0000;
	endfunction

	// only view select is writable in the command shadow
	task automatic model_wr(input logic [15:0] a, input logic [15:0] d);
		if (a == DMA1_MODE_ADDR) m[{1'b0, d[1:0]}] = d[7:2];
		else if (a == DMA2_MODE_ADDR) m[{1'b1, d[1:0]}] = d[7:2];
		else if (a == DMA1_CMD_ADDR) c[0] = {d[5], d[4], d[2]};
		else if (a == DMA2_CMD_ADDR) c[1] = {d[5], d[4], d[2]};
		else if (a == SHADOW_CMD_ADDR) v = d[15];
	endtask

	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask

	// ****************************************
	// drivers: each strobe set once per step, so calls may run back to back
	// ****************************************
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		io_wr = 1'b1;
		io_rd = 1'b0;
		io_addr = a;
		io_wdata = d;
		@(posedge clk);
		#1;
		model_wr(a, d);
		chk1("view_select", v, view_select);
		chk1("io_rvalid", 1'b0, io_rvalid);
	endtask

	task automatic rd(input logic [15:0] a);
		logic [15:0] e;
		e = expv(a);
		io_wr = 1'b0;
		io_rd = 1'b1;
		io_addr = a;
		@(posedge clk);
		#1;
		chk1("io_rvalid", 1'b1, io_rvalid);
		chk16("io_rdata", e, io_rdata);
	endtask

	// reset held ten cycles; all outputs are checked once for zero at its end
	task automatic do_reset();
		io_wr = 1'b0;
		io_rd = 1'b0;
		reset = 1'b1;
		m = '{default: 6'h00};
		c = '{default: 3'h0};
		v = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		chk16("rdata_rst", 16'h0000, io_rdata);
		chk1("view_rst", 1'b0, view_select);
		chk1("rvalid_rst", 1'b0, io_rvalid);
		reset = 1'b0;
	endtask

	task automatic print_verdict();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{io_addr, io_wdata} = 32'h0000_0000;
		num_errors = 0;
		samples_checked = 0;
		dma_base_value = 16'hB1A5;
		dma_current_value = 16'h0C3E;
		timer_base_count = 16'h7E21;
		timer_current_count = 16'h4D96;
		do_reset();
		rd(SHADOW_LOW_ADDR);
		rd(SHADOW_CMD_ADDR);
		$display("test reset done");
		// table rows: write then read at once, covering every channel and view
		foreach (rows[i]) begin
			wr(rows[i][47:32], rows[i][31:16]);
			rd(rows[i][15:0]);
		end
		$display("test rows done");
		// back-to-back reads while the live sources move
		dma_current_value = 16'h2F4C;
		timer_current_count = 16'h91D3;
		rd(16'h0005);
		rd(16'h0041);
		wr(SHADOW_CMD_ADDR, 16'hFFFF);
		dma_base_value = 16'h6A0E;
		rd(16'h0002);
		rd(16'h0042);
		rd(SHADOW_CMD_ADDR);
		$display("test view switch done");
		// second reset in mid-run clears shadows and view
		do_reset();
		rd(SHADOW_MID_ADDR);
		rd(SHADOW_CMD_ADDR);
		$display("test mid reset done");
		print_verdict();
	end

	// watchdog against a hung run
	initial begin
		#2000000;
		num_errors++;
		print_verdict();
	end
endmodule // suspend_state_shadow_readback_bench
